/* core/drmc_cfg.svh */
// Purpose: constants for the converter reference and mode control block
// Assumes: included by its bare name from the package and the modules
// Notes: command word is 24 bits, nibble in [23:20]
// Operation
// - eight independent channels, each holding a code that selects a string tap.
// - codes are unsigned 0..4095, output is code over 4096 times reference.
// - small package is straight binary; large package follows the coding select pin.
// - internal reference is off after reset until a valid enabling command.
// - static and flexible modes; flexible only when the flexible mode bit is one.
// - static command nibble 1000 with enable bit one turns the reference on.
// - same static command with enable bit zero turns the reference off.
// - enabled static reference powers down once every channel is powered down.
// - enabled static reference powers up again when any channel powers up.
// - external reference gives gain one; internal reference shorts divider for gain two.
// - reference pin undriven while internal reference off; channels use external reference.
// - in flexible mode static commands do nothing until flexible bit cleared.
`ifndef DRMC_CFG_SVH
`define DRMC_CFG_SVH
`define DRMC_CHANNELS 8
`define DRMC_CODE_W 12
`define DRMC_CMD_W 24
`define DRMC_NIB_HI 23
`define DRMC_NIB_LO 20
`define DRMC_FLEX_BIT 14
`define DRMC_FLEX_SEL_HI 13
`define DRMC_FLEX_SEL_LO 12
`define DRMC_REF_EN_BIT 4
`define DRMC_NIB_REF_STATIC 4'h8
`define DRMC_NIB_REF_FLEX 4'h9
`define DRMC_FLEX_ON_TRACK 2'h0
`define DRMC_FLEX_ON_ALWAYS 2'h1
`define DRMC_FLEX_OFF 2'h2
`define DRMC_ADR_CTRL 4'h0
`define DRMC_ADR_CMD 4'h4
`define DRMC_ADR_PD 4'h8
`define DRMC_ADR_STAT 4'hC
`define DRMC_ADR_CODE_BASE 6'h20
`define DRMC_CTRL_TWOS_COMPLEMENT_SELECT_BIT 0
`define DRMC_CTRL_PKG_BIT 1
`define DRMC_ST_REF_BIT 0
`define DRMC_ST_FLEX_BIT 1
`define DRMC_ST_EN_BIT 2
`define DRMC_ST_GAIN2_BIT 3
`define DRMC_ST_ALW_BIT 4
`endif

/* core/drmc_chan.sv */
// Purpose: one converter channel code holder with coding conversion
// Assumes: write strobe is one cycle
// Notes: two's complement is mapped to offset binary by inverting the msb
`timescale 1ns/1ps
`default_nettype none
`include "drmc_cfg.svh"
module drmc_chan
  import drmc_pkg::*;
#(
  parameter int CODE_W = `DRMC_CODE_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic twos_i,
  input wire logic [CODE_W-1:0] data_i,
  output logic [CODE_W-1:0] tap_o
);
  logic [CODE_W-1:0] tap_q;
  wire [CODE_W-1:0] conv = twos_i ? {~data_i[CODE_W-1], data_i[CODE_W-2:0]} : data_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tap_q <= '0;
    end else if (ce_i && we_i) begin
      tap_q <= conv;
    end
  end
  assign tap_o = tap_q;
endmodule : drmc_chan
`default_nettype wire

/* core/drmc_cmd_dec.sv */
// Purpose: decode a 24-bit reference command into update requests
// Assumes: cmd_valid_i is a one-cycle strobe
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "drmc_cfg.svh"
module drmc_cmd_dec
  import drmc_pkg::*;
(
  input wire logic cmd_valid_i,
  input wire logic [`DRMC_CMD_W-1:0] cmd_i,
  input wire logic flex_mode_i,
  output logic static_on_o,
  output logic static_off_o,
  output logic flex_on_track_o,
  output logic flex_on_always_o,
  output logic flex_off_o,
  output logic to_static_o
);
  wire [3:0] nib = cmd_i[`DRMC_NIB_HI:`DRMC_NIB_LO];
  wire flexible_mode_bit = cmd_i[`DRMC_FLEX_BIT];
  wire reference_enable_bit = cmd_i[`DRMC_REF_EN_BIT];
  wire [1:0] fsel = cmd_i[`DRMC_FLEX_SEL_HI:`DRMC_FLEX_SEL_LO];
  // only nibble, mode bit, selector and enable bit are looked at
  wire is_static = cmd_valid_i && (nib == `DRMC_NIB_REF_STATIC) && !flex_mode_i;
  wire is_flex = cmd_valid_i && (nib == `DRMC_NIB_REF_FLEX);
  assign static_on_o = is_static && reference_enable_bit;
  assign static_off_o = is_static && !reference_enable_bit;
  assign flex_on_track_o = is_flex && flexible_mode_bit && (fsel == `DRMC_FLEX_ON_TRACK);
  assign flex_on_always_o = is_flex && flexible_mode_bit && (fsel == `DRMC_FLEX_ON_ALWAYS);
  assign flex_off_o = is_flex && flexible_mode_bit && (fsel == `DRMC_FLEX_OFF)
                      && !reference_enable_bit;
  assign to_static_o = is_flex && !flexible_mode_bit;
endmodule : drmc_cmd_dec
`default_nettype wire

/* core/drmc_pkg.sv */
// Purpose: types for the reference and mode control block
// Assumes: drmc_cfg.svh holds the numbers
// Notes: types only
`include "drmc_cfg.svh"
package drmc_pkg;
  typedef enum logic [2:0] {
    DRMC_REF_OFF = 3'h1,
    DRMC_REF_TRACK = 3'h2,
    DRMC_REF_ALWAYS = 3'h4
  } drmc_ref_type;
  typedef logic [`DRMC_CMD_W-1:0] drmc_cmd_type;
endpackage : drmc_pkg

/* core/drmc_top.sv */
// Purpose: reference and mode control of an eight-channel 12-bit converter
// Assumes: classic wishbone slave, single clock, synchronous reset
// Notes: command register write delivers the 24-bit command after addressing
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "drmc_cfg.svh"
module drmc_top
  import drmc_pkg::*;
#(
  parameter int CHANNELS = `DRMC_CHANNELS,
  parameter int CODE_W = `DRMC_CODE_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [CHANNELS*CODE_W-1:0] tap_code_o,
  output logic ref_on_o,
  output logic reference_pin_oe_n_o,
  output logic gain_divider_short_o
);
  drmc_ref_type ref_q;
  logic flex_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic twos_q;
  logic large_pkg_q;
  logic [CHANNELS-1:0] pd_q;
  logic ref_on_q;
  logic oe_n_q;
  logic gain2_q;
  // each channel instance drives its own slice, so this is a net
  wire logic [CHANNELS*CODE_W-1:0] taps;
  logic [CHANNELS*CODE_W-1:0] tap_q;

  // decode
  wire req = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr = req && wb_we_i;
  wire sel_ctrl = wb_adr_i[5:2] == `DRMC_ADR_CTRL >> 2;
  wire sel_cmd = wb_adr_i[5:2] == `DRMC_ADR_CMD >> 2;
  wire sel_pd = wb_adr_i[5:2] == `DRMC_ADR_PD >> 2;
  wire sel_stat = wb_adr_i[5:2] == `DRMC_ADR_STAT >> 2;
  wire sel_code = wb_adr_i[5];
  wire [2:0] code_idx = wb_adr_i[4:2];
  // the 24-bit command needs its three low lanes in one access
  wire cmd_stb = wr && sel_cmd && (wb_sel_i[2:0] == 3'h7);
  wire twos_eff = twos_q && large_pkg_q;
  wire all_pd = &pd_q;

  logic s_on, s_off, f_track, f_alw, f_off, to_stat;
  drmc_cmd_dec u_dec (
    .cmd_valid_i(cmd_stb),
    .cmd_i(wb_dat_i[`DRMC_CMD_W-1:0]),
    .flex_mode_i(flex_q),
    .static_on_o(s_on),
    .static_off_o(s_off),
    .flex_on_track_o(f_track),
    .flex_on_always_o(f_alw),
    .flex_off_o(f_off),
    .to_static_o(to_stat)
  );

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      wire we_ch = wr && sel_code && (code_idx == 3'(g)) && (wb_sel_i[1:0] == 2'h3);
      drmc_chan #(.CODE_W(CODE_W)) u_ch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .we_i(we_ch),
        .twos_i(twos_eff),
        .data_i(wb_dat_i[CODE_W-1:0]),
        .tap_o(taps[g*CODE_W +: CODE_W])
      );
    end
  endgenerate

  // read mux
  wire [31:0] stat_w = {27'h0, ref_q == DRMC_REF_ALWAYS, gain2_q, ref_q != DRMC_REF_OFF,
                        flex_q, ref_on_q};
  wire [31:0] code_w = {20'h0, taps[code_idx*CODE_W +: CODE_W]};
  wire [31:0] rd_w = sel_code ? code_w :
                     sel_ctrl ? {30'h0, large_pkg_q, twos_q} :
                     sel_pd ? {24'h0, pd_q} :
                     sel_stat ? stat_w : 32'h0;

  // reference state: tracking powers follow channel power, always ignores it
  wire ref_live = (ref_q == DRMC_REF_ALWAYS) || ((ref_q == DRMC_REF_TRACK) && !all_pd);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else if (ce_i) begin
      ack_q <= req;
      dat_q <= req ? rd_w : 32'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      twos_q <= 1'b0;
      large_pkg_q <= 1'b0;
      pd_q <= '0;
    end else if (ce_i && wr) begin
      if (sel_ctrl && wb_sel_i[0]) begin
        twos_q <= wb_dat_i[`DRMC_CTRL_TWOS_COMPLEMENT_SELECT_BIT];
        large_pkg_q <= wb_dat_i[`DRMC_CTRL_PKG_BIT];
      end
      if (sel_pd && wb_sel_i[0]) begin
        pd_q <= wb_dat_i[CHANNELS-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_q <= DRMC_REF_OFF;
      flex_q <= 1'b0;
    end else if (ce_i) begin
      case (ref_q)
        DRMC_REF_OFF, DRMC_REF_TRACK, DRMC_REF_ALWAYS: begin
          if (s_on || f_track) begin
            ref_q <= DRMC_REF_TRACK;
          end else if (f_alw) begin
            ref_q <= DRMC_REF_ALWAYS;
          end else if (s_off || f_off) begin
            ref_q <= DRMC_REF_OFF;
          end
        end
        default: ref_q <= DRMC_REF_OFF;
      endcase
      if (f_track || f_alw || f_off) begin
        flex_q <= 1'b1;
      end else if (to_stat) begin
        flex_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_on_q <= 1'b0;
      oe_n_q <= 1'b1;
      gain2_q <= 1'b0;
      tap_q <= '0;
    end else if (ce_i) begin
      ref_on_q <= ref_live;
      oe_n_q <= !ref_live;
      gain2_q <= ref_live;
      tap_q <= taps;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign tap_code_o = tap_q;
  assign ref_on_o = ref_on_q;
  assign reference_pin_oe_n_o = oe_n_q;
  assign gain_divider_short_o = gain2_q;
endmodule : drmc_top
`default_nettype wire

/* verif/drmc_top_asserts.sv */
// Purpose: port checks of bus answer and reference state
// Assumes: one clock, sync reset, ce_i held high by the bench
// Notes: mode and power-down state are shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none
module drmc_top_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic ref_on_o,
  input wire logic reference_pin_oe_n_o,
  input wire logic gain_divider_short_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic flex_q;
  logic [7:0] pd_q;
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  wire wt = take && wb_we_i;
  wire cmd = wt && wb_adr_i == 6'h04 && wb_sel_i[2:0] == 3'h7;
  wire pdw = wt && wb_adr_i == 6'h08 && wb_sel_i[0];
  // shadow only what the checks need; unsupported flex selects are never sent
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flex_q <= 1'b0;
      pd_q <= 8'h00;
    end else begin
      if (cmd && wb_dat_i[23:20] == 4'h9) flex_q <= wb_dat_i[14];
      if (pdw) pd_q <= wb_dat_i[7:0];
    end
  end
  sequence st_cmd(en);
    cmd && wb_dat_i[23:20] == 4'h8 && wb_dat_i[4] == en && !flex_q;
  endsequence
  sequence fx_cmd;
    cmd && wb_dat_i[23:20] == 4'h8 && flex_q;
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_latency_a: assert property (take |=> wb_ack_o)
    else $error("ack late");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  static_on_a: assert property (st_cmd(1'b1) ##0 pd_q != 8'hFF |=> ##1 ref_on_o)
    else $error("static enable ignored");
  static_off_a: assert property (st_cmd(1'b0) |=> ##1 !ref_on_o)
    else $error("static disable ignored");
  flex_hold_a: assert property (fx_cmd |=> ##1 $stable(ref_on_o))
    else $error("static command acted in flex mode");
  track_down_a: assert property (pdw && wb_dat_i[7:0] == 8'hFF && !flex_q |=> ##1 !ref_on_o)
    else $error("reference kept with all channels down");
  gain_ref_a: assert property (gain_divider_short_o == ref_on_o)
    else $error("gain does not follow reference");
  pin_ref_a: assert property (reference_pin_oe_n_o == !ref_on_o)
    else $error("reference pin drive wrong");
  // the write is taken two edges before the registered reference output moves
  ref_rise_a: assert property ($rose(ref_on_o) |-> $past(wt, 2))
    else $error("reference rose without a write");
endmodule : drmc_top_asserts
bind drmc_top drmc_top_asserts drmc_top_asserts_i (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ref_on_o,
  .reference_pin_oe_n_o, .gain_divider_short_o);
`default_nettype wire

/* verif/drmc_wb_master.sv */
// Purpose: classic wishbone master standing in for the bus controller
// Assumes: slave acks some cycles after the request
// Notes: waits without limit; the bench watchdog ends a hang
`timescale 1ns/1ps
`default_nettype none
module drmc_wb_master (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [5:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 6'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  task xfer(input logic w, input logic [5:0] a, input logic [3:0] s, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
  endtask : xfer
endmodule : drmc_wb_master
`default_nettype wire

/* verif/tb_top.sv */
// Purpose: directed bench for reference mode and channel code handling
// Assumes: ce_i held high throughout
// Notes: reference outputs are sampled one edge after the bus answer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst, ce, cyc, stb, we, ack, ref_on, oe_n, gain;
  logic [5:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr;
  logic [95:0] taps;
  int mismatches = 0;
  int check_count = 0;
  drmc_top drmc_top_i (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .tap_code_o(taps), .ref_on_o(ref_on), .reference_pin_oe_n_o(oe_n),
    .gain_divider_short_o(gain));
  drmc_wb_master drmc_wb_master_i (.clk_i(clk), .ack_i(ack), .dat_i(dr), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dw));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [5:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    drmc_wb_master_i.xfer(1'b1, a, s, d, q);
  endtask : wr
  task rd(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    drmc_wb_master_i.xfer(1'b0, a, 4'hF, 32'h0, q);
    chk("rdata", q, e);
  endtask : rd
  task refc(input logic e);
    @(posedge clk);
    chk("ref", {29'h0, ref_on, oe_n, gain}, {29'h0, e, !e, e});
  endtask : refc
  task final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    final_report;
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    refc(1'b0);
    rd(6'h0C, 32'h0);
    $display("test reset done");
    // don't-care bits all set, so a decoder that looks at them misbehaves
    wr(6'h04, 4'hF, 32'h008F_FFFF);
    refc(1'b1);
    wr(6'h04, 4'h3, 32'h0080_0000);
    refc(1'b1);
    wr(6'h04, 4'hF, 32'h008F_FFEF);
    refc(1'b0);
    wr(6'h04, 4'hF, 32'h0080_0010);
    wr(6'h08, 4'h1, 32'hFF);
    refc(1'b0);
    wr(6'h08, 4'h1, 32'h7F);
    refc(1'b1);
    $display("test static done");
    wr(6'h04, 4'hF, 32'h0090_5000);
    wr(6'h08, 4'h1, 32'hFF);
    refc(1'b1);
    rd(6'h0C, 32'h1F);
    wr(6'h04, 4'hF, 32'h0080_0000);
    refc(1'b1);
    wr(6'h04, 4'hF, 32'h0090_6000);
    refc(1'b0);
    wr(6'h04, 4'hF, 32'h0090_4000);
    refc(1'b0);
    wr(6'h08, 4'h1, 32'h0);
    refc(1'b1);
    wr(6'h04, 4'hF, 32'h0090_0000);
    wr(6'h04, 4'hF, 32'h0080_0000);
    refc(1'b0);
    $display("test flex done");
    wr(6'h20, 4'h3, 32'hFFF);
    wr(6'h3C, 4'h3, 32'h0);
    rd(6'h20, 32'hFFF);
    chk("tap0", {20'h0, taps[11:0]}, 32'hFFF);
    wr(6'h00, 4'h1, 32'h3);
    wr(6'h24, 4'h3, 32'h800);
    rd(6'h24, 32'h0);
    wr(6'h00, 4'h1, 32'h1);
    wr(6'h24, 4'h3, 32'h800);
    rd(6'h24, 32'h800);
    wr(6'h10, 4'hF, 32'hFFFF_FFFF);
    rd(6'h10, 32'h0);
    $display("test codes done");
    final_report;
  end
endmodule : tb_top
`default_nettype wire
